/* File: shared/iocb_params.svh */
// timing counts, address decode constants and field positions
`ifndef IOCB_PARAMS_SVH
`define IOCB_PARAMS_SVH

// clock period in ns
`define IOCB_CLK_PERIOD_NS 40
// write hold threshold and uart hold in ns
`define IOCB_HOLD_LATCH_NS 7
`define IOCB_UART_HOLD_NS 12
// uart read inactive needs and natural spacing in ns
`define IOCB_UART_RD_GAP_NS 123
`define IOCB_NATURAL_GAP_NS 116
// extra clocks of read inactive time, rounded up, at least one
`define IOCB_UART_GAP_CLKS (((`IOCB_UART_RD_GAP_NS - `IOCB_NATURAL_GAP_NS) + `IOCB_CLK_PERIOD_NS - 1) / `IOCB_CLK_PERIOD_NS)
// wait states
`define IOCB_UART_RD_WAITS 4'h9
`define IOCB_UART_WR_EXTRA 4'h2
`define IOCB_GEN_WAITS 4'h0
// strobe delay after chip select, clocks (1 or 2)
`define IOCB_SETUP_CLKS 2'h2
// address decode
`define IOCB_UART_BASE_HI 8'h07
`define IOCB_UART_A20 20
`define IOCB_UART_A19 19
`define IOCB_UART_PORT_LSB 16
`define IOCB_EPROM_TOP_BITS 7'h7f
`define IOCB_CODE_BIT 24
`endif

/* File: shared/iocb_pkg.sv */
// types shared by the io cycle control block
package iocb_pkg;
    typedef enum logic [2:0]
    {
        IOCB_IDLE = 3'b000,
        IOCB_SETUP = 3'b001,
        IOCB_STROBE = 3'b010,
        IOCB_HOLD = 3'b011,
        IOCB_GAP = 3'b100
    } iocb_state_t;

    typedef struct packed
    {
        logic io_region_select;
        logic uart_chip_select;
        logic eprom_chip_enable_n;
        logic code_access;
        logic [2:0] uart_port;
    } iocb_decode_t;

    typedef struct packed
    {
        logic start;
        logic write;
        logic [31:0] addr;
        logic [2:0] byte_enable_lines;
        logic [7:0] wdata;
    } iocb_req_t;
endpackage

/* File: hdl/iocb_decode.sv */
// address decode for uart, io region and eprom
`timescale 1ns/100ps
`default_nettype none
`include "iocb_params.svh"
module iocb_decode
(
    // request address and remap
    input wire logic [31:0] addr,
    input wire logic boot_remap,
    // decoded selects
    output iocb_pkg::iocb_decode_t dec
);
    import iocb_pkg::*;

    always_comb
    begin
        dec = '0;
        // uart range on 64 KB boundaries, byte on lane zero
        dec.uart_chip_select = (addr[31:24] == `IOCB_UART_BASE_HI) &&
            !addr[`IOCB_UART_A20] && !addr[`IOCB_UART_A19];
        dec.uart_port = addr[`IOCB_UART_PORT_LSB +: 3];
        // top 32 MB: eprom region, 16 x 2 MB
        if (boot_remap)
        begin
            dec.eprom_chip_enable_n = !(addr[31:25] ==
                `IOCB_EPROM_TOP_BITS);
        end
        else
        begin
            dec.eprom_chip_enable_n = !((addr[31:25] ==
                `IOCB_EPROM_TOP_BITS) && !addr[`IOCB_CODE_BIT]);
        end
        dec.code_access = addr[`IOCB_CODE_BIT];
        dec.io_region_select = dec.uart_chip_select ||
            !dec.eprom_chip_enable_n;
    end
endmodule
`default_nettype wire

/* File: hdl/iocb_addr_mux.sv */
// eprom low address and data lane selection
`timescale 1ns/100ps
`default_nettype none
module iocb_addr_mux
(
    // selects
    input wire logic boot_remap,
    input wire logic code_access,
    // sources
    input wire logic [2:0] byte_enable_lines,
    input wire logic [2:0] proc_addr_bits,
    input wire logic [7:0] lane_a,
    input wire logic [7:0] lane_b,
    // results
    output logic [2:0] eprom_low_addr,
    output logic [7:0] lane_out
);
    always_comb
    begin
        eprom_low_addr = boot_remap ? byte_enable_lines
            : proc_addr_bits;
        lane_out = code_access ? lane_b : lane_a;
    end
endmodule
`default_nettype wire

/* File: hdl/iocb_ctrl.sv */
// io cycle control: strobes, wait states, acknowledge, boot map
`timescale 1ns/100ps
`default_nettype none
`include "iocb_params.svh"
// Function
// - write strobe one/two clocks after select
// - latched data allows early acknowledge
// - strobe held until data setup met
// - strobe width one clock plus waits
// - latched chip select governs setup
// - zero-wait data setup about four clocks
// - hold over 7ns: latch data
// - uart ports on 64 KB boundaries
// - uart select from two address bits
// - uart reads take nine wait states
// - extra clock between uart reads
// - uart write strobe two clocks longer
// - uart hold: latch data, acknowledge early
// - remap bit places eprom at boot
// - remap bit muxes eprom low address
// - top 32 MB addresses eprom with remap set, only its lower 16 MB without
// - address bit 24 enables caching of eprom cycles
// - bit 24 selects data mux b
module iocb_ctrl
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // processor request
    input wire iocb_pkg::iocb_req_t req,
    input wire logic boot_remap,
    input wire logic [7:0] eprom_lane_a,
    input wire logic [7:0] eprom_lane_b,
    // processor answer
    output logic cycle_ack_n,
    output logic cache_enable_n,
    output logic [7:0] read_lane,
    // peripheral side
    output logic io_region_select,
    output logic uart_chip_select,
    output logic eprom_chip_enable_n,
    output logic io_write_strobe_n,
    output logic io_read_strobe_n,
    output logic [2:0] periph_addr,
    output logic [7:0] periph_wdata,
    output logic [2:0] eprom_low_addr
);
    import iocb_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed
    {
        iocb_state_t state;
        logic [1:0] setup_cnt;
        logic [3:0] wait_cnt;
        logic [1:0] gap_cnt;
        logic write;
        logic uart;
        logic last_uart_read;
        logic ack_n;
        logic ken_n;
        logic wr_n;
        logic rd_n;
        logic io_sel;
        logic uart_sel;
        logic eprom_ce_n;
        logic [2:0] paddr;
        logic [7:0] wdata;
        logic [2:0] low_addr;
        logic [7:0] lane;
        logic code;
    } iocb_ctrl_state_t;

    iocb_ctrl_state_t s_reg;
    iocb_ctrl_state_t s_next;
    iocb_decode_t dec;
    logic [2:0] mux_low_addr;
    logic [7:0] mux_lane;

    // ************************************************************
    // decode and multiplexers
    // ************************************************************
    iocb_decode u_decode
    (
        .addr(req.addr),
        .boot_remap(boot_remap),
        .dec(dec)
    );

    iocb_addr_mux u_mux
    (
        .boot_remap(boot_remap),
        .code_access(s_reg.code),
        .byte_enable_lines(req.byte_enable_lines),
        .proc_addr_bits(req.addr[2:0]),
        .lane_a(eprom_lane_a),
        .lane_b(eprom_lane_b),
        .eprom_low_addr(mux_low_addr),
        .lane_out(mux_lane)
    );

    // wait states loaded per peripheral at cycle start
    function automatic logic [3:0] load_waits(input logic uart,
        input logic wr);
        logic [3:0] w;
        w = `IOCB_GEN_WAITS;
        if (uart && wr)
        begin
            w = `IOCB_UART_WR_EXTRA;
        end
        else if (uart)
        begin
            w = `IOCB_UART_RD_WAITS;
        end
        return w;
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        s_next = s_reg;
        s_next.ack_n = 1'b1;
        s_next.lane = mux_lane;
        unique case (s_reg.state)
            IOCB_IDLE:
            begin
                if (req.start && dec.io_region_select)
                begin
                    // latch address, select and data
                    s_next.io_sel = 1'b1;
                    s_next.uart_sel = dec.uart_chip_select;
                    s_next.eprom_ce_n = dec.eprom_chip_enable_n;
                    s_next.paddr = dec.uart_port;
                    s_next.low_addr = mux_low_addr;
                    s_next.code = dec.code_access;
                    s_next.ken_n = !(dec.code_access &&
                        !dec.eprom_chip_enable_n);
                    s_next.wdata = req.wdata;
                    s_next.write = req.write;
                    s_next.uart = dec.uart_chip_select;
                    s_next.wait_cnt = load_waits(dec.uart_chip_select,
                        req.write);
                    s_next.setup_cnt = `IOCB_SETUP_CLKS;
                    s_next.state = IOCB_SETUP;
                    // latched data: acknowledge at once
                    if (req.write)
                    begin
                        s_next.ack_n = 1'b0;
                    end
                end
            end
            IOCB_SETUP:
            begin
                s_next.setup_cnt = s_reg.setup_cnt - 2'h1;
                if (s_reg.setup_cnt == 2'h1)
                begin
                    if (!s_reg.write && s_reg.uart &&
                        s_reg.last_uart_read && s_reg.gap_cnt != 2'h0)
                    begin
                        // hold off next uart read strobe
                        s_next.setup_cnt = 2'h1;
                        s_next.gap_cnt = s_reg.gap_cnt - 2'h1;
                    end
                    else
                    begin
                        s_next.wr_n = !s_reg.write;
                        s_next.rd_n = s_reg.write;
                        s_next.state = IOCB_STROBE;
                    end
                end
            end
            IOCB_STROBE:
            begin
                // one clock plus wait states
                if (s_reg.wait_cnt == 4'h0)
                begin
                    s_next.wr_n = 1'b1;
                    s_next.rd_n = 1'b1;
                    s_next.state = IOCB_HOLD;
                    if (!s_reg.write)
                    begin
                        s_next.ack_n = 1'b0;
                    end
                end
                else
                begin
                    s_next.wait_cnt = s_reg.wait_cnt - 4'h1;
                end
            end
            IOCB_HOLD:
            begin
                // data and selects held one clock past strobe
                s_next.io_sel = 1'b0;
                s_next.uart_sel = 1'b0;
                s_next.eprom_ce_n = 1'b1;
                s_next.ken_n = 1'b1;
                s_next.last_uart_read = s_reg.uart && !s_reg.write;
                s_next.gap_cnt = 2'(`IOCB_UART_GAP_CLKS);
                s_next.state = IOCB_GAP;
            end
            IOCB_GAP:
            begin
                s_next.state = IOCB_IDLE;
            end
            default:
            begin
                s_next.state = IOCB_IDLE;
            end
        endcase
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            s_reg <= '0;
            s_reg.state <= IOCB_IDLE;
            s_reg.ack_n <= 1'b1;
            s_reg.ken_n <= 1'b1;
            s_reg.wr_n <= 1'b1;
            s_reg.rd_n <= 1'b1;
            s_reg.eprom_ce_n <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    always_comb
    begin
        cycle_ack_n = s_reg.ack_n;
        cache_enable_n = s_reg.ken_n;
        read_lane = s_reg.lane;
        io_region_select = s_reg.io_sel;
        uart_chip_select = s_reg.uart_sel;
        eprom_chip_enable_n = s_reg.eprom_ce_n;
        io_write_strobe_n = s_reg.wr_n;
        io_read_strobe_n = s_reg.rd_n;
        periph_addr = s_reg.paddr;
        periph_wdata = s_reg.wdata;
        eprom_low_addr = s_reg.low_addr;
    end
endmodule
`default_nettype wire

/* File: verification/iocb_ctrl_sva.sv */
// port assertions for the io cycle control block
`timescale 1ns/100ps
`default_nettype none
module iocb_ctrl_sva
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // watched ports
    input wire iocb_pkg::iocb_req_t req,
    input wire logic cycle_ack_n,
    input wire logic cache_enable_n,
    input wire logic uart_chip_select,
    input wire logic eprom_chip_enable_n,
    input wire logic io_write_strobe_n,
    input wire logic io_read_strobe_n,
    input wire logic [2:0] periph_addr
);
    import iocb_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // *****
    // checks
    // *****
    ack_pulse_a: assert property (
        !cycle_ack_n |=> cycle_ack_n) else $error("ack too long");
    wr_setup_a: assert property (
        $fell(io_write_strobe_n) |->
        $past(uart_chip_select, 2) && !$past(uart_chip_select, 3))
        else $error("write strobe setup");
    wr_width_a: assert property (
        $fell(io_write_strobe_n) && uart_chip_select |->
        !io_write_strobe_n [*3] ##1 io_write_strobe_n)
        else $error("write strobe width");
    early_ack_a: assert property (
        $fell(io_write_strobe_n) |-> !$past(cycle_ack_n, 2))
        else $error("write ack not early");
    rd_ack_a: assert property (
        $rose(io_read_strobe_n) |-> !cycle_ack_n)
        else $error("read ack not at strobe end");
    rd_width_a: assert property (
        $fell(io_read_strobe_n) && uart_chip_select |->
        !io_read_strobe_n [*8] ##1 !io_read_strobe_n [*2]
        ##1 io_read_strobe_n) else $error("read strobe width");
    ken_code_a: assert property (
        $fell(eprom_chip_enable_n) |->
        cache_enable_n == !$past(req.addr[24]))
        else $error("cache enable");
    uart_port_a: assert property (
        $rose(uart_chip_select) |->
        periph_addr == $past(req.addr[18:16])) else $error("uart port");
endmodule
bind iocb_ctrl iocb_ctrl_sva i_iocb_ctrl_sva (.sys_clk, .reset, .req,
    .cycle_ack_n, .cache_enable_n, .uart_chip_select, .eprom_chip_enable_n,
    .io_write_strobe_n, .io_read_strobe_n, .periph_addr);
`default_nettype wire

/* File: verification/iocb_periph_model.sv */
// far side model: uart port and byte-wide eprom
`timescale 1ns/100ps
`default_nettype none
module iocb_periph_model
(
    // clock
    input wire logic sys_clk,
    // strobes and selects
    input wire logic io_write_strobe_n,
    input wire logic io_read_strobe_n,
    input wire logic eprom_chip_enable_n,
    // address and data
    input wire logic [2:0] eprom_low_addr,
    input wire logic [2:0] periph_addr,
    input wire logic [7:0] periph_wdata,
    output logic [7:0] lane_a,
    output logic [7:0] lane_b,
    output logic [7:0] wr_data,
    output logic [2:0] wr_port
);
    logic [7:0] noise_reg = 8'h00;
    logic rd_on;
    always_ff @(posedge sys_clk)
    begin
        noise_reg <= noise_reg + 8'h01;
    end
    // uart takes data on the strobe's rising edge
    always @(posedge io_write_strobe_n)
    begin
        wr_data = periph_wdata;
        wr_port = periph_addr;
    end
    // undriven lanes float: changing pattern
    assign rd_on = !eprom_chip_enable_n && !io_read_strobe_n;
    assign lane_a = rd_on ? {5'h10, eprom_low_addr} : ~noise_reg;
    assign lane_b = rd_on ? {5'h18, eprom_low_addr} : noise_reg;
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the io cycle control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
    import iocb_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    iocb_req_t req = '0;
    logic boot_remap = 1'b1;
    logic [7:0] lane_a, lane_b, read_lane, periph_wdata, wr_data;
    logic cycle_ack_n, cache_enable_n, io_region_select, uart_chip_select;
    logic eprom_chip_enable_n, io_write_strobe_n, io_read_strobe_n;
    logic [2:0] periph_addr, eprom_low_addr, wr_port;
    int n_errors = 0;
    int tests_run = 0;
    iocb_ctrl i_iocb_ctrl (.sys_clk, .reset, .req, .boot_remap,
        .eprom_lane_a(lane_a), .eprom_lane_b(lane_b), .cycle_ack_n,
        .cache_enable_n, .read_lane, .io_region_select, .uart_chip_select,
        .eprom_chip_enable_n, .io_write_strobe_n, .io_read_strobe_n,
        .periph_addr, .periph_wdata, .eprom_low_addr);
    iocb_periph_model i_iocb_periph_model (.sys_clk, .io_write_strobe_n,
        .io_read_strobe_n, .eprom_chip_enable_n, .eprom_low_addr,
        .periph_addr, .periph_wdata, .lane_a, .lane_b, .wr_data, .wr_port);
    // *****
    // one io cycle: latency to ack, data and cache enable at ack
    // *****
    task automatic io_cycle(input logic wr, input logic [31:0] a,
        input logic [2:0] be, output int lat, output logic [7:0] rd,
        output logic ken_n);
        lat = 0;
        @(posedge sys_clk) #1;
        req = '{1'b1, wr, a, be, {5'h15, a[18:16]}};
        @(posedge sys_clk) #1;
        req.start = 1'b0;
        for (int i = 1; i < 40 && lat == 0; i++)
        begin
            if (cycle_ack_n === 1'b0)
                lat = i;
            else
                @(posedge sys_clk) #1;
        end
        rd = read_lane;
        ken_n = cache_enable_n;
        req.wdata = 8'h00;
        repeat (40)
            if (uart_chip_select !== 1'b0 || eprom_chip_enable_n !== 1'b1)
                @(posedge sys_clk) #1;
    endtask
    task automatic end_sim;
        if (n_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // *****
    // scenarios
    // *****
    task automatic t_uart;
        int lat, l1;
        logic [7:0] rd;
        logic k;
        io_cycle(1'b1, 32'h0703_0000, 3'h0, lat, rd, k);
        `CHK(lat, 1)
        `CHK(wr_data, 8'hab)
        `CHK(wr_port, 3'h3)
        io_cycle(1'b1, 32'h0718_0000, 3'h0, lat, rd, k);
        `CHK(lat, 0)
        io_cycle(1'b0, 32'h0705_0000, 3'h0, l1, rd, k);
        io_cycle(1'b0, 32'h0705_0000, 3'h0, lat, rd, k);
        `CHK(lat - l1, 1)
    endtask
    task automatic t_eprom;
        int lat;
        logic [7:0] rd;
        logic k;
        for (int b = 0; b < 8; b++)
        begin
            io_cycle(1'b0, 32'hff00_0000, b[2:0], lat, rd, k);
            `CHK(lat, 4)
            `CHK(rd, {5'h18, b[2:0]})
            `CHK(k, 1'b0)
            io_cycle(1'b0, 32'hfe00_0000, b[2:0], lat, rd, k);
            `CHK(rd, {5'h10, b[2:0]})
            `CHK(k, 1'b1)
        end
        boot_remap = 1'b0;
        io_cycle(1'b0, 32'hff00_0000, 3'h0, lat, rd, k);
        `CHK(lat, 0)
        io_cycle(1'b0, 32'hfe00_0000, 3'h0, lat, rd, k);
        `CHK(lat, 4)
    endtask
    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end
    initial
    begin
        #(40 * 3000);
        n_errors++;
        end_sim();
    end
    initial
    begin
        repeat (16) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        t_uart();
        t_eprom();
        end_sim();
    end
endmodule
`default_nettype wire
